// File: design/aotc_cfg.svh
// Purpose: constants for the converter output, test and clock config bank
// Assumes: 13-bit register addresses on the serial configuration port
// Notes:   masks clear the unused bits, which read back as zero
`ifndef AOTC_CFG_SVH
`define AOTC_CFG_SVH

`define AOTC_ADDR_GCS      13'h0009
`define AOTC_ADDR_DIV      13'h000B
`define AOTC_ADDR_TEST     13'h000D
`define AOTC_ADDR_OFFS     13'h0010
`define AOTC_ADDR_OMODE    13'h0014
`define AOTC_ADDR_PHASE    13'h0016
`define AOTC_ADDR_SDLY     13'h0017

`define AOTC_RST_GCS       8'h01
`define AOTC_RST_DIV       8'h00
`define AOTC_RST_TEST      8'h00
`define AOTC_RST_OFFS      8'h00
`define AOTC_RST_OMODE     8'h00
`define AOTC_RST_PHASE     8'h00
`define AOTC_RST_SDLY      8'h00

`define AOTC_MSK_GCS       8'h01
`define AOTC_MSK_DIV       8'h07
`define AOTC_MSK_TEST      8'h37
`define AOTC_MSK_OFFS      8'h3F
`define AOTC_MSK_OMODE     8'hF7
`define AOTC_MSK_PHASE     8'h87
`define AOTC_MSK_SDLY      8'h1F

`define AOTC_TEST_LONG_RST 5
`define AOTC_TEST_SHRT_RST 4
`define AOTC_OM_OE_N       4
`define AOTC_OM_INVERT     2
`define AOTC_PH_STB_INV    7

`define AOTC_CODE_MID      12'h800
`define AOTC_CODE_PFS      12'hFFF
`define AOTC_CODE_NFS      12'h000
`define AOTC_CODE_CHK      12'hAAA
`define AOTC_SEED_LONG     23'h7FFFFF
`define AOTC_SEED_SHRT     9'h1FF

`define AOTC_INSTR_LAST    5'h0F
`define AOTC_DATA_LAST     5'h07

`endif

// File: design/aotc_pkg.sv
// Purpose: types for the converter output, test and clock config bank
// Assumes: nothing
// Notes:   pattern codes match the 3-bit test selector field
package aotc_pkg;

   typedef enum logic [2:0]
   {
      TP_OFF  = 3'h0,
      TP_MID  = 3'h1,
      TP_PFS  = 3'h2,
      TP_NFS  = 3'h3,
      TP_CHK  = 3'h4,
      TP_PNL  = 3'h5,
      TP_PNS  = 3'h6,
      TP_TOG  = 3'h7
   } aotc_pat_e;

   typedef enum logic [1:0]
   {
      FMT_OBIN  = 2'h0,
      FMT_TWOS  = 2'h1,
      FMT_GRAY  = 2'h2,
      FMT_OBIN2 = 2'h3
   } aotc_fmt_e;

   typedef enum logic [2:0]
   {
      SP_IDLE  = 3'b001,
      SP_INSTR = 3'b010,
      SP_DATA  = 3'b100
   } aotc_spi_e;

   typedef struct packed
   {
      aotc_pat_e sel;
      logic      rst_long;
      logic      rst_short;
   } aotc_tcfg_s;

   typedef struct packed
   {
      logic clk;
      logic cs_n;
      logic din;
   } aotc_spi_s;

endpackage

// File: design/aotc_pattern_gen.sv
// Purpose: output test pattern source
// Assumes: pattern replaces converter data one clock after it is produced
// Notes:   pn generators run freely so a selector change picks up mid-stream
`timescale 1ns/10ps
module aotc_pattern_gen
(
   // clock and reset
   input  wire logic                clk_in,
   input  wire logic                reset_n_in,
   // configuration
   input  wire aotc_pkg::aotc_tcfg_s tcfg_in,
   // pattern
   output logic [11:0]              pat_out
);
   import aotc_pkg::*;
   `include "aotc_cfg.svh"

   logic [22:0] pn_long_r;
   logic [8:0]  pn_short_r;

   // long sequence x^23 + x^18 + 1, held at seed while its reset bit is set
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         pn_long_r <= `AOTC_SEED_LONG;
      else if (tcfg_in.rst_long)
         pn_long_r <= `AOTC_SEED_LONG;
      else
         pn_long_r <= {pn_long_r[21:0], pn_long_r[22] ^ pn_long_r[17]};
   end

   // short sequence x^9 + x^5 + 1
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         pn_short_r <= `AOTC_SEED_SHRT;
      else if (tcfg_in.rst_short)
         pn_short_r <= `AOTC_SEED_SHRT;
      else
         pn_short_r <= {pn_short_r[7:0], pn_short_r[8] ^ pn_short_r[4]};
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         pat_out <= 12'h000;
      else
      begin
         unique case (tcfg_in.sel)
            TP_OFF : pat_out <= 12'h000;
            TP_MID : pat_out <= `AOTC_CODE_MID;  // R1
            TP_PFS : pat_out <= `AOTC_CODE_PFS;  // R1
            TP_NFS : pat_out <= `AOTC_CODE_NFS;  // R1
            // first word after selection is the checker code
            TP_CHK : pat_out <= (pat_out == `AOTC_CODE_CHK) ?
                                ~`AOTC_CODE_CHK : `AOTC_CODE_CHK;  // R2
            TP_PNL : pat_out <= pn_long_r[11:0];                   // R2
            TP_PNS : pat_out <= {pn_short_r[2:0], pn_short_r};     // R2
            TP_TOG : pat_out <= (pat_out == `AOTC_CODE_PFS) ?
                                `AOTC_CODE_NFS : `AOTC_CODE_PFS;   // R2
         endcase
      end
   end

   a_fixed_codes: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      tcfg_in.sel inside {TP_MID, TP_PFS, TP_NFS} |=>
      pat_out == ($past(tcfg_in.sel) == TP_MID ? `AOTC_CODE_MID :
                  $past(tcfg_in.sel) == TP_PFS ? `AOTC_CODE_PFS :
                  `AOTC_CODE_NFS))
      else $error("fixed test code wrong"); // R1

   a_checker_alt: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (tcfg_in.sel == TP_CHK) [*2] |=>
      (pat_out == ~$past(pat_out)) && (pat_out inside {12'hAAA, 12'h555}))
      else $error("checkerboard does not alternate"); // R2

   a_word_toggle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (tcfg_in.sel == TP_TOG) [*2] |=>
      (pat_out == ~$past(pat_out)) && (pat_out inside {12'hFFF, 12'h000}))
      else $error("word toggle wrong"); // R2

   c_pn_long: cover property (@(posedge clk_in) disable iff (!reset_n_in)
      (tcfg_in.sel == TP_PNL) [*4]);

endmodule

// File: design/aotc_top.sv
// Purpose: output test pattern, data format and clock configuration bank
// Assumes: serial port pins sampled on CLK_IN; SPI clock well below CLK_IN
// Notes:   one byte per frame; writes take effect at the last data bit
// Summary of operation
// R1: selector 000 off, 001 midscale, 010 positive, 011 negative full scale.
// R2: 100 checkerboard, 101 long pn, 110 short pn, 111 ones/zeros toggle.
// R3: any selected pattern replaces converter samples on the output pins.
// R4: format 00/11 offset binary, 01 twos complement, 10 gray code.
// R5: divider phase delayed by 0 to 7 input clock cycles.
// R6: nonzero divide ratio forces duty-cycle stabilizer on.
`timescale 1ns/10ps
module aotc_top
(
   // clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        RESET_N_IN,
   // serial configuration port
   input  wire logic        SPI_CLK_IN,
   input  wire logic        SPI_CS_N_IN,
   input  wire logic        SPI_DATA_IN,
   output logic             SPI_DATA_OUT,
   output logic             SPI_DATA_OE_N_OUT,
   // converter samples in, formatted data out
   input  wire logic [11:0] SAMPLE_IN,
   output logic [11:0]      DATA_OUT,
   output logic             DATA_OE_N_OUT,
   // clocking and trims
   output logic             DIV_STROBE_OUT,
   output logic             OUTPUT_DATA_STROBE_OUT,
   output logic             DCS_EN_OUT,
   output logic [4:0]       STROBE_DELAY_OUT,
   output logic [5:0]       OFFSET_TRIM_OUT
);
   import aotc_pkg::*;
   `include "aotc_cfg.svh"

   logic [7:0]  global_clock_stabilizer_r;
   logic [7:0]  clock_divide_ratio_r;
   logic [7:0]  output_test_pattern_r;
   logic [7:0]  converter_offset_trim_r;
   logic [7:0]  output_format_config_r;
   logic [7:0]  clock_phase_config_r;
   logic [7:0]  output_clock_delay_r;

   aotc_spi_s   spi_q_r;
   aotc_spi_e   spi_st_r;
   logic [4:0]  cnt_r;
   logic [14:0] ish_r;
   logic [7:0]  dsh_r;
   logic [7:0]  rsh_r;
   logic        rd_r;
   logic [12:0] addr_r;
   logic        rise;
   logic        fall;
   logic        cs_fall;

   aotc_tcfg_s  tcfg;
   logic [11:0] pat;
   logic [11:0] pre_fmt;
   logic [2:0]  div_cnt_r;
   logic        div_pulse_r;
   logic [7:0]  dly_line_r;
   logic        dly_pulse;

   function automatic logic [7:0] reg_read(input logic [12:0] a);
      unique case (a)
         `AOTC_ADDR_GCS   : reg_read = global_clock_stabilizer_r;
         `AOTC_ADDR_DIV   : reg_read = clock_divide_ratio_r;
         `AOTC_ADDR_TEST  : reg_read = output_test_pattern_r;
         `AOTC_ADDR_OFFS  : reg_read = converter_offset_trim_r;
         `AOTC_ADDR_OMODE : reg_read = output_format_config_r;
         `AOTC_ADDR_PHASE : reg_read = clock_phase_config_r;
         `AOTC_ADDR_SDLY  : reg_read = output_clock_delay_r;
         default          : reg_read = 8'h00;
      endcase
   endfunction

   function automatic logic [11:0] fmt_conv(input logic [11:0] v,
                                            input logic [7:0]  om);
      logic [11:0] r;
      r = v;
      unique case (aotc_fmt_e'(om[1:0]))
         FMT_OBIN, FMT_OBIN2 : r = v;                        // R4
         FMT_TWOS            : r = {~v[11], v[10:0]};        // R4
         FMT_GRAY            : r = v ^ {1'b0, v[11:1]};      // R4
      endcase
      if (om[`AOTC_OM_INVERT])
         r = ~r;
      fmt_conv = r;
   endfunction

   // serial port: pins are synchronous, so one stage finds the edges
   assign rise    = spi_q_r.cs_n == 1'b0 && SPI_CLK_IN && !spi_q_r.clk;
   assign fall    = !SPI_CLK_IN && spi_q_r.clk;
   assign cs_fall = spi_q_r.cs_n && !SPI_CS_N_IN;

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         spi_q_r <= '{clk: 1'b0, cs_n: 1'b1, din: 1'b0};
      else
         spi_q_r <= '{clk: SPI_CLK_IN, cs_n: SPI_CS_N_IN, din: SPI_DATA_IN};
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         spi_st_r <= SP_IDLE;
         cnt_r    <= 5'h00;
         ish_r    <= 15'h0000;
         dsh_r    <= 8'h00;
         rd_r     <= 1'b0;
         addr_r   <= 13'h0000;
      end
      else if (SPI_CS_N_IN)
      begin
         spi_st_r <= SP_IDLE;
         cnt_r    <= 5'h00;
         rd_r     <= 1'b0;
      end
      else
      begin
         unique case (spi_st_r)
            SP_IDLE :
               if (cs_fall)
                  spi_st_r <= SP_INSTR;
            SP_INSTR :
               if (rise)
               begin
                  ish_r <= {ish_r[13:0], SPI_DATA_IN};
                  cnt_r <= cnt_r + 5'h01;
                  if (cnt_r == `AOTC_INSTR_LAST)
                  begin
                     rd_r     <= ish_r[14];
                     addr_r   <= {ish_r[11:0], SPI_DATA_IN};
                     cnt_r    <= 5'h00;
                     spi_st_r <= SP_DATA;
                  end
               end
            SP_DATA :
               if (rise)
               begin
                  dsh_r <= {dsh_r[6:0], SPI_DATA_IN};
                  cnt_r <= cnt_r + 5'h01;
                  // single byte per frame; wait for chip select to rise
                  if (cnt_r == `AOTC_DATA_LAST)
                     spi_st_r <= SP_IDLE;
               end
         endcase
      end
   end

   // read data: first bit out as soon as the address is known
   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         rsh_r             <= 8'h00;
         SPI_DATA_OUT      <= 1'b0;
         SPI_DATA_OE_N_OUT <= 1'b1;
      end
      else if (SPI_CS_N_IN)
         SPI_DATA_OE_N_OUT <= 1'b1;
      else if (spi_st_r == SP_INSTR && rise && cnt_r == `AOTC_INSTR_LAST)
      begin
         rsh_r             <= reg_read({ish_r[11:0], SPI_DATA_IN}) << 1;
         SPI_DATA_OUT      <= (reg_read({ish_r[11:0], SPI_DATA_IN}) >> 7) !=
                              8'h00;
         SPI_DATA_OE_N_OUT <= !ish_r[14];
      end
      else if (spi_st_r == SP_DATA && fall && cnt_r != 5'h00)
      begin
         SPI_DATA_OUT <= rsh_r[7];
         rsh_r        <= {rsh_r[6:0], 1'b0};
      end
      else if (spi_st_r == SP_IDLE)
         SPI_DATA_OE_N_OUT <= 1'b1;
   end

   // register writes land on the eighth data bit
   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         global_clock_stabilizer_r <= `AOTC_RST_GCS;
         clock_divide_ratio_r      <= `AOTC_RST_DIV;
         output_test_pattern_r     <= `AOTC_RST_TEST;
         converter_offset_trim_r   <= `AOTC_RST_OFFS;
         output_format_config_r    <= `AOTC_RST_OMODE;
         clock_phase_config_r      <= `AOTC_RST_PHASE;
         output_clock_delay_r      <= `AOTC_RST_SDLY;
      end
      else if (spi_st_r == SP_DATA && rise && !rd_r &&
               cnt_r == `AOTC_DATA_LAST && !SPI_CS_N_IN)
      begin
         unique case (addr_r)
            `AOTC_ADDR_GCS   : global_clock_stabilizer_r <=
                                  {dsh_r[6:0], SPI_DATA_IN} & `AOTC_MSK_GCS;
            `AOTC_ADDR_DIV   : clock_divide_ratio_r <=
                                  {dsh_r[6:0], SPI_DATA_IN} & `AOTC_MSK_DIV;
            `AOTC_ADDR_TEST  : output_test_pattern_r <=
                                  {dsh_r[6:0], SPI_DATA_IN} & `AOTC_MSK_TEST;
            `AOTC_ADDR_OFFS  : converter_offset_trim_r <=
                                  {dsh_r[6:0], SPI_DATA_IN} & `AOTC_MSK_OFFS;
            `AOTC_ADDR_OMODE : output_format_config_r <=
                                  {dsh_r[6:0], SPI_DATA_IN} & `AOTC_MSK_OMODE;
            `AOTC_ADDR_PHASE : clock_phase_config_r <=
                                  {dsh_r[6:0], SPI_DATA_IN} & `AOTC_MSK_PHASE;
            `AOTC_ADDR_SDLY  : output_clock_delay_r <=
                                  {dsh_r[6:0], SPI_DATA_IN} & `AOTC_MSK_SDLY;
            default          : ;
         endcase
      end
   end

   // data path
   assign tcfg = '{sel:       aotc_pat_e'(output_test_pattern_r[2:0]),
                   rst_long:  output_test_pattern_r[`AOTC_TEST_LONG_RST],
                   rst_short: output_test_pattern_r[`AOTC_TEST_SHRT_RST]};

   aotc_pattern_gen u_pat
   (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .tcfg_in    (tcfg),
      .pat_out    (pat)
   );

   // the mux follows the live selector: off takes effect at once, a new pattern first shows the stale pattern word
   assign pre_fmt = (tcfg.sel == TP_OFF) ? SAMPLE_IN : pat;   // R3

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         DATA_OUT      <= 12'h000;
         DATA_OE_N_OUT <= 1'b0;
      end
      else
      begin
         DATA_OUT      <= fmt_conv(pre_fmt, output_format_config_r); // R3
         DATA_OE_N_OUT <= output_format_config_r[`AOTC_OM_OE_N];
      end
   end

   // divider: ratio field n divides by n+1
   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         div_cnt_r   <= 3'h0;
         div_pulse_r <= 1'b0;
      end
      else
      begin
         div_cnt_r   <= (div_cnt_r >= clock_divide_ratio_r[2:0]) ?
                        3'h0 : div_cnt_r + 3'h1;
         div_pulse_r <= div_cnt_r == 3'h0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         dly_line_r <= 8'h00;
      else
         dly_line_r <= {dly_line_r[6:0], div_pulse_r};
   end

   // tap 0 is the undelayed pulse, tap n is n input clocks later
   assign dly_pulse = (clock_phase_config_r[2:0] == 3'h0) ? div_pulse_r :
                      dly_line_r[clock_phase_config_r[2:0] - 3'h1];  // R5

   always_ff @(posedge CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         DIV_STROBE_OUT         <= 1'b0;
         OUTPUT_DATA_STROBE_OUT <= 1'b0;
         DCS_EN_OUT             <= 1'b1;
         STROBE_DELAY_OUT       <= 5'h00;
         OFFSET_TRIM_OUT        <= 6'h00;
      end
      else
      begin
         DIV_STROBE_OUT         <= dly_pulse;                        // R5
         OUTPUT_DATA_STROBE_OUT <= dly_pulse ^
                                   clock_phase_config_r[`AOTC_PH_STB_INV];
         DCS_EN_OUT             <= global_clock_stabilizer_r[0] ||
                                   clock_divide_ratio_r[2:0] != 3'h0; // R6
         STROBE_DELAY_OUT       <= output_clock_delay_r[4:0];
         OFFSET_TRIM_OUT        <= converter_offset_trim_r[5:0];
      end
   end

   a_pattern_replaces: assert property (@(posedge CLK_IN)
      disable iff (!RESET_N_IN)
      tcfg.sel != TP_OFF |=>
      DATA_OUT == fmt_conv($past(pat), $past(output_format_config_r)))
      else $error("test pattern not on data pins"); // R3

   a_twos_format: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (tcfg.sel == TP_OFF && output_format_config_r[2:0] == 3'h1) |=>
      DATA_OUT == {~$past(SAMPLE_IN[11]), $past(SAMPLE_IN[10:0])})
      else $error("twos complement format wrong"); // R4

   a_obin_format: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (tcfg.sel == TP_OFF && output_format_config_r[2:0] inside {3'h0, 3'h3})
      |=> DATA_OUT == $past(SAMPLE_IN))
      else $error("offset binary format wrong"); // R4

   a_phase_three: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      (clock_phase_config_r[2:0] == 3'h3) [*4] |=>
      DIV_STROBE_OUT == $past(div_pulse_r, 4))
      else $error("divider phase delay wrong"); // R5

   a_dcs_forced: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      clock_divide_ratio_r[2:0] != 3'h0 |=> DCS_EN_OUT)
      else $error("stabilizer not forced on"); // R6

   c_reg_write: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      $changed(output_test_pattern_r));

   c_read_frame: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      !SPI_DATA_OE_N_OUT && spi_st_r == SP_DATA);

   c_gray_out: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
      output_format_config_r[1:0] == 2'h2 && tcfg.sel == TP_OFF);

endmodule

// File: dv/tb.sv
// Purpose: self-checking bench for the output test, format and clock bank
// Assumes: serial frames of 24 bits, SPI clock phases of 2 CLK_IN periods
// Notes:   design assertions live in the design files; no checker here
`timescale 1ns/10ps
`include "aotc_cfg.svh"
module tb;
   import aotc_pkg::*;

   logic        CLK_IN;
   logic        RESET_N_IN;
   logic        SPI_CLK_IN;
   logic        SPI_CS_N_IN;
   logic        SPI_DATA_IN;
   logic        SPI_DATA_OUT;
   logic        SPI_DATA_OE_N_OUT;
   logic [11:0] SAMPLE_IN;
   logic [11:0] DATA_OUT;
   logic        DATA_OE_N_OUT;
   logic        DIV_STROBE_OUT;
   logic        OUTPUT_DATA_STROBE_OUT;
   logic        DCS_EN_OUT;
   logic [4:0]  STROBE_DELAY_OUT;
   logic [5:0]  OFFSET_TRIM_OUT;
   int          miscompares = 0;
   int          checked = 0;
   int          cyc = 0;
   int          t0;
   int          t1;
   logic [11:0] pv;
   logic [12:0] adr [7] = '{`AOTC_ADDR_GCS, `AOTC_ADDR_DIV, `AOTC_ADDR_TEST,
      `AOTC_ADDR_OFFS, `AOTC_ADDR_OMODE, `AOTC_ADDR_PHASE, `AOTC_ADDR_SDLY};
   logic [7:0]  rst [7] = '{`AOTC_RST_GCS, `AOTC_RST_DIV, `AOTC_RST_TEST,
      `AOTC_RST_OFFS, `AOTC_RST_OMODE, `AOTC_RST_PHASE, `AOTC_RST_SDLY};
   logic [7:0]  msk [7] = '{`AOTC_MSK_GCS, `AOTC_MSK_DIV, `AOTC_MSK_TEST,
      `AOTC_MSK_OFFS, `AOTC_MSK_OMODE, `AOTC_MSK_PHASE, `AOTC_MSK_SDLY};
   logic [11:0] fix [3] = '{`AOTC_CODE_MID, `AOTC_CODE_PFS, `AOTC_CODE_NFS};

   aotc_top i_dut
   (
      .CLK_IN                 (CLK_IN),
      .RESET_N_IN             (RESET_N_IN),
      .SPI_CLK_IN             (SPI_CLK_IN),
      .SPI_CS_N_IN            (SPI_CS_N_IN),
      .SPI_DATA_IN            (SPI_DATA_IN),
      .SPI_DATA_OUT           (SPI_DATA_OUT),
      .SPI_DATA_OE_N_OUT      (SPI_DATA_OE_N_OUT),
      .SAMPLE_IN              (SAMPLE_IN),
      .DATA_OUT               (DATA_OUT),
      .DATA_OE_N_OUT          (DATA_OE_N_OUT),
      .DIV_STROBE_OUT         (DIV_STROBE_OUT),
      .OUTPUT_DATA_STROBE_OUT (OUTPUT_DATA_STROBE_OUT),
      .DCS_EN_OUT             (DCS_EN_OUT),
      .STROBE_DELAY_OUT       (STROBE_DELAY_OUT),
      .OFFSET_TRIM_OUT        (OFFSET_TRIM_OUT)
   );

   initial
   begin
      CLK_IN = 1'b0;
      forever #20 CLK_IN = ~CLK_IN;
   end

   always @(posedge CLK_IN)
      cyc <= cyc + 1;

   task automatic tick(input int n);
      repeat (n) @(posedge CLK_IN);
      #1;
   endtask

   task automatic check(input string nm, input logic [15:0] got,
                        input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("mismatches %0d of %0d compares", miscompares, checked);
      if (miscompares == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // one byte per frame; read data sampled just before each data rise
   task automatic xfer(input logic rd, input logic [12:0] a,
                       input logic [7:0] w, output logic [7:0] r);
      logic [23:0] f;
      f = {rd, 2'b00, a, w};
      r = 8'h00;
      SPI_CS_N_IN = 1'b0;
      tick(1);
      for (int i = 23; i >= 0; i--)
      begin
         SPI_DATA_IN = f[i];
         tick(2);
         if (i < 8)
            r[i] = SPI_DATA_OUT;
         if (i == 0 && rd)
            check("sdo_oe", {15'h0, SPI_DATA_OE_N_OUT}, 16'h0000);
         SPI_CLK_IN = 1'b1;
         tick(2);
         SPI_CLK_IN = 1'b0;
      end
      tick(2);
      SPI_CS_N_IN = 1'b1;
      tick(2);
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] w);
      logic [7:0] d;
      xfer(1'b0, a, w, d);
   endtask

   task automatic rchk(input logic [12:0] a, input logic [7:0] e);
      logic [7:0] d;
      xfer(1'b1, a, 8'h00, d);
      check("register", {8'h00, d}, {8'h00, e});
   endtask

   // bounded wait for the divided-clock pulse, returns its cycle
   task automatic next_pulse(output int t);
      int n;
      n = 0;
      while (DIV_STROBE_OUT !== 1'b1 && n < 40)
      begin
         tick(1);
         n++;
      end
      if (n == 40)
      begin
         miscompares++;
         finish_test();
      end
      else
      begin
         t = cyc;
         tick(1);
      end
   endtask

   // drive a sample, then look at the output one clock later
   task automatic dpath(input logic [11:0] s, input logic [11:0] e);
      SAMPLE_IN = s;
      tick(1);
      check("data", {4'h0, DATA_OUT}, {4'h0, e});
   endtask

   initial
   begin
      RESET_N_IN = 1'b0;
      SPI_CLK_IN = 1'b0;
      SPI_CS_N_IN = 1'b1;
      SPI_DATA_IN = 1'b0;
      SAMPLE_IN = 12'h000;
      tick(4);
      RESET_N_IN = 1'b1;
      tick(1);
      check("dcs", {15'h0, DCS_EN_OUT}, 16'h0001);
      check("oe", {15'h0, SPI_DATA_OE_N_OUT}, 16'h0001);
      for (int k = 0; k < 7; k++)
         rchk(adr[k], rst[k]);
      // unused bits must read back as zero after an all-ones write
      for (int k = 0; k < 7; k++)
      begin
         wr(adr[k], 8'hFF);
         rchk(adr[k], msk[k]);
      end
      check("trim", {10'h0, OFFSET_TRIM_OUT}, 16'h003F);
      check("sdly", {11'h0, STROBE_DELAY_OUT}, 16'h001F);
      check("doe", {15'h0, DATA_OE_N_OUT}, 16'h0001);
      wr(13'h000A, 8'hFF);
      rchk(13'h000A, 8'h00);
      for (int k = 0; k < 7; k++)
         wr(adr[k], 8'h00);
      // formats on live samples
      dpath(12'h5A3, 12'h5A3);
      wr(`AOTC_ADDR_OMODE, 8'h01);
      dpath(12'h5A3, 12'hDA3);
      wr(`AOTC_ADDR_OMODE, 8'h02);
      dpath(12'h5A3, 12'h5A3 ^ 12'h2D1);
      wr(`AOTC_ADDR_OMODE, 8'h03);
      dpath(12'hC3C, 12'hC3C);
      wr(`AOTC_ADDR_OMODE, 8'h04);
      dpath(12'h5A3, 12'hA5C);
      wr(`AOTC_ADDR_OMODE, 8'h00);
      // fixed codes, checkerboard, toggle and held pn seeds replace the sample
      for (int k = 0; k < 3; k++)
      begin
         wr(`AOTC_ADDR_TEST, 8'(k + 1));
         dpath(12'h123, fix[k]);
      end
      wr(`AOTC_ADDR_OMODE, 8'h01);
      wr(`AOTC_ADDR_TEST, 8'h01);
      dpath(12'h123, 12'h000);
      wr(`AOTC_ADDR_OMODE, 8'h00);
      wr(`AOTC_ADDR_TEST, 8'h04);
      dpath(12'h123, DATA_OUT[0] ? 12'hAAA : 12'h555);
      pv = DATA_OUT;
      tick(1);
      check("chk", {4'h0, DATA_OUT}, {4'h0, ~pv});
      wr(`AOTC_ADDR_TEST, 8'h07);
      dpath(12'h123, DATA_OUT[0] ? 12'h000 : 12'hFFF);
      wr(`AOTC_ADDR_TEST, 8'h25);
      dpath(12'h123, 12'hFFF);
      wr(`AOTC_ADDR_TEST, 8'h16);
      dpath(12'h123, 12'hFFF);
      wr(`AOTC_ADDR_TEST, 8'h00);
      dpath(12'h123, 12'h123);
      // stabilizer enable follows the divide ratio
      wr(`AOTC_ADDR_GCS, 8'h00);
      check("dcs", {15'h0, DCS_EN_OUT}, 16'h0000);
      wr(`AOTC_ADDR_DIV, 8'h07);
      check("dcs", {15'h0, DCS_EN_OUT}, 16'h0001);
      // divide by eight, then shift the phase by the maximum seven
      next_pulse(t0);
      next_pulse(t1);
      check("period", 16'(t1 - t0), 16'h0008);
      wr(`AOTC_ADDR_PHASE, 8'h87);
      next_pulse(t1);
      check("phase", 16'((t1 - t0) % 8), 16'h0007);
      check("strobe", {15'h0, OUTPUT_DATA_STROBE_OUT}, 16'h0001);
      wr(`AOTC_ADDR_PHASE, 8'h03);
      next_pulse(t1);
      check("phase", 16'((t1 - t0) % 8), 16'h0003);
      check("strobe", {15'h0, OUTPUT_DATA_STROBE_OUT}, 16'h0000);
      tick(3);
      finish_test();
   end
endmodule
